// ---- temp_sensor_regs.sv ----
// register file, status flags, alert latch and thermal outputs of the monitor
`timescale 1ns/1ps
module temp_sensor_regs #(
   parameter longint FAST_CYC = tsense_pkg::FAST_PERIOD_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic index_wr,
   input wire logic [7:0] index_wdata,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   input wire logic data_rd,
   input wire logic alert_response,
   input wire tsense_pkg::limits_t limits,
   input wire logic conv_done,
   input wire tsense_pkg::sample_t sample,
   output logic [7:0] rd_data,
   output logic conv_start,
   output logic alert_n,
   output logic thermal_limit_output_n,
   output logic secondary_thermal_output_n,
   output logic [7:0] register_index
);
   // ==========================================================
   // declarations
   logic [7:0] cfg_q;
   logic [7:0] rate_q;
   logic [11:0] local_q;
   logic [11:0] remote_q;
   logic lock_local_hi_q;
   logic lock_local_lo_q;
   logic lock_remote_hi_q;
   logic lock_remote_lo_q;
   logic local_over_high_flag;
   logic local_under_low_flag;
   logic remote_over_high_flag;
   logic remote_under_low_flag;
   logic remote_open_flag;
   logic remote_thermal_limit_flag;
   logic local_thermal_limit_flag;
   logic alert_latch_q;
   logic local_crit_q;
   logic remote_crit_q;
   logic busy;
   logic done_q;
   tsense_pkg::compare_t cmp;
   tsense_pkg::compare_t cmp_q;
   logic [11:0] code_local;
   logic [11:0] code_remote;
   logic alert_bit_mode;
   logic alert_mask_bit;
   logic shutdown_bit;
   logic pin_function_select;
   logic range_bit;
   logic status_rd;
   logic [7:0] status_byte;
   logic [7:0] rd_mux;

   // configuration fields
   assign alert_mask_bit = cfg_q[tsense_pkg::CFG_MASK_BIT];
   assign shutdown_bit = cfg_q[tsense_pkg::CFG_SHUTDOWN_BIT];
   assign pin_function_select = cfg_q[tsense_pkg::CFG_PIN_FUNC_BIT];
   assign range_bit = cfg_q[tsense_pkg::CFG_RANGE_BIT];
   assign alert_bit_mode = !pin_function_select;
   assign status_rd = data_rd && register_index == tsense_pkg::IDX_STATUS;

   // ==========================================================
   // sequencer and comparator
   conv_sequencer #(
      .FAST_CYC(FAST_CYC)
   ) i_conv_sequencer (
      .clock(clock),
      .rst(rst),
      .shutdown(shutdown_bit),
      .one_shot(data_wr && register_index == tsense_pkg::IDX_ONE_SHOT),
      .rate_code(rate_q[3:0]),
      .conv_done(conv_done),
      .conv_start(conv_start),
      .busy(busy)
   );

   limit_compare i_limit_compare (
      .range_ext(range_bit),
      .sample(sample),
      .limits(limits),
      .result(cmp)
   );

   // stored-format results for the registers
   assign code_local = range_bit ? sample.local_temp + tsense_pkg::EXT_OFFSET
                                 : (sample.local_temp[11] ? 12'h000 : sample.local_temp);
   assign code_remote = range_bit ? sample.remote_temp + tsense_pkg::EXT_OFFSET
                                  : (sample.remote_temp[11] ? 12'h000 : sample.remote_temp);

   // ==========================================================
   // register index, reloaded on every index write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         register_index <= tsense_pkg::INDEX_RESET;
      end else if (index_wr) begin
         register_index <= index_wdata;
      end
   end

   // configuration and rate writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_q <= tsense_pkg::CFG_RESET;
         rate_q <= tsense_pkg::RATE_RESET;
      end else if (data_wr) begin
         if (register_index == tsense_pkg::IDX_CFG_WR) begin
            cfg_q <= data_wdata & tsense_pkg::CFG_WR_MASK;
         end
         if (register_index == tsense_pkg::IDX_RATE_WR) begin
            rate_q <= {4'h0, data_wdata[3:0]};
         end
      end
   end

   // byte locks: reading one half freezes the other; its partner read frees both
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lock_local_hi_q <= 1'b0;
         lock_local_lo_q <= 1'b0;
         lock_remote_hi_q <= 1'b0;
         lock_remote_lo_q <= 1'b0;
      end else if (data_rd) begin
         lock_local_lo_q <= register_index == tsense_pkg::IDX_LOCAL_HI &&
                            !lock_local_hi_q;
         lock_local_hi_q <= register_index == tsense_pkg::IDX_LOCAL_LO &&
                            !lock_local_lo_q;
         lock_remote_lo_q <= register_index == tsense_pkg::IDX_REMOTE_HI &&
                             !lock_remote_hi_q;
         lock_remote_hi_q <= register_index == tsense_pkg::IDX_REMOTE_LO &&
                             !lock_remote_lo_q;
      end
   end

   // result registers refreshed per conversion unless locked
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         local_q <= 12'h000;
         remote_q <= 12'h000;
      end else if (conv_done) begin
         if (!lock_local_hi_q) local_q[11:4] <= code_local[11:4];
         if (!lock_local_lo_q) local_q[3:0] <= code_local[3:0];
         if (!lock_remote_hi_q) remote_q[11:4] <= code_remote[11:4];
         if (!lock_remote_lo_q) remote_q[3:0] <= code_remote[3:0];
      end
   end

   // comparison outcome held from the latest conversion
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmp_q <= '0;
         done_q <= 1'b0;
      end else begin
         done_q <= conv_done;
         if (conv_done) cmp_q <= cmp;
      end
   end

   // ==========================================================
   // limit flags: latching in alert mode; set wins over read-clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         local_over_high_flag <= 1'b0;
         local_under_low_flag <= 1'b0;
         remote_over_high_flag <= 1'b0;
         remote_under_low_flag <= 1'b0;
         remote_open_flag <= 1'b0;
      end else begin
         if (done_q && cmp_q.remote_open) begin
            remote_open_flag <= 1'b1;
         end else if (status_rd && !cmp_q.remote_open) begin
            remote_open_flag <= 1'b0;
         end
         if (!alert_bit_mode) begin
            // secondary mode: high and low flags follow the comparison directly
            local_over_high_flag <= cmp_q.local_high;
            remote_over_high_flag <= cmp_q.remote_high;
            local_under_low_flag <= cmp_q.local_low;
            remote_under_low_flag <= cmp_q.remote_low;
         end else begin
            if (done_q && cmp_q.local_high) local_over_high_flag <= 1'b1;
            else if (status_rd && !cmp_q.local_high) local_over_high_flag <= 1'b0;
            if (done_q && cmp_q.local_low) local_under_low_flag <= 1'b1;
            else if (status_rd && !cmp_q.local_low) local_under_low_flag <= 1'b0;
            if (done_q && cmp_q.remote_high) remote_over_high_flag <= 1'b1;
            else if (status_rd && !cmp_q.remote_high) remote_over_high_flag <= 1'b0;
            if (done_q && cmp_q.remote_low) remote_under_low_flag <= 1'b1;
            else if (status_rd && !cmp_q.remote_low) remote_under_low_flag <= 1'b0;
         end
      end
   end

   // alert latch: set by any latched flag, cleared by alert-response read
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         alert_latch_q <= 1'b0;
      end else if (alert_bit_mode && (local_over_high_flag || local_under_low_flag ||
                   remote_over_high_flag || remote_under_low_flag || remote_open_flag)) begin
         alert_latch_q <= 1'b1;
      end else if (alert_response && !(cmp_q.local_high || cmp_q.local_low ||
                   cmp_q.remote_high || cmp_q.remote_low || cmp_q.remote_open)) begin
         alert_latch_q <= 1'b0;
      end else if (!alert_bit_mode) begin
         alert_latch_q <= 1'b0;
      end
   end

   // thermal flags with hysteresis, no read needed
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         local_crit_q <= 1'b0;
         remote_crit_q <= 1'b0;
      end else if (done_q) begin
         if (cmp_q.local_crit) local_crit_q <= 1'b1;
         else if (cmp_q.local_crit_clear) local_crit_q <= 1'b0;
         if (cmp_q.remote_crit) remote_crit_q <= 1'b1;
         else if (cmp_q.remote_crit_clear) remote_crit_q <= 1'b0;
      end
   end
   assign local_thermal_limit_flag = local_crit_q;
   assign remote_thermal_limit_flag = remote_crit_q;

   // ==========================================================
   // pin drivers, all registered
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         alert_n <= 1'b1;
         thermal_limit_output_n <= 1'b1;
         secondary_thermal_output_n <= 1'b1;
      end else begin
         alert_n <= !(alert_bit_mode && !alert_mask_bit && alert_latch_q);
         thermal_limit_output_n <= !(local_crit_q || remote_crit_q);
         secondary_thermal_output_n <= !(!alert_bit_mode &&
                                         (local_over_high_flag || remote_over_high_flag));
      end
   end

   // ==========================================================
   // read data selection
   assign status_byte = {busy, local_over_high_flag, local_under_low_flag,
                         remote_over_high_flag, remote_under_low_flag, remote_open_flag,
                         remote_thermal_limit_flag, local_thermal_limit_flag};
   always_comb begin
      unique case (register_index)
         tsense_pkg::IDX_LOCAL_HI: rd_mux = local_q[11:4];
         tsense_pkg::IDX_LOCAL_LO: rd_mux = {local_q[3:0], 4'h0};
         tsense_pkg::IDX_REMOTE_HI: rd_mux = remote_q[11:4];
         tsense_pkg::IDX_REMOTE_LO: rd_mux = {remote_q[3:0], 4'h0};
         tsense_pkg::IDX_STATUS: rd_mux = status_byte;
         tsense_pkg::IDX_CFG_RD: rd_mux = cfg_q;
         tsense_pkg::IDX_RATE_RD: rd_mux = rate_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // read byte registered each cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_mux;
      end
   end
endmodule // temp_sensor_regs

// ---- tsense_pkg.sv ----
// shared constants and types for the temperature monitor register block
package tsense_pkg;
   // ==========================================================
   // register indices
   localparam logic [7:0] IDX_LOCAL_HI = 8'h00;
   localparam logic [7:0] IDX_REMOTE_HI = 8'h01;
   localparam logic [7:0] IDX_STATUS = 8'h02;
   localparam logic [7:0] IDX_CFG_RD = 8'h03;
   localparam logic [7:0] IDX_RATE_RD = 8'h04;
   localparam logic [7:0] IDX_CFG_WR = 8'h09;
   localparam logic [7:0] IDX_RATE_WR = 8'h0a;
   localparam logic [7:0] IDX_ONE_SHOT = 8'h0f;
   localparam logic [7:0] IDX_REMOTE_LO = 8'h10;
   localparam logic [7:0] IDX_LOCAL_LO = 8'h15;
   // ==========================================================
   // reset values and field positions
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] RATE_RESET = 8'h08;
   localparam logic [7:0] CFG_WR_MASK = 8'he4;
   localparam int CFG_MASK_BIT = 7;
   localparam int CFG_SHUTDOWN_BIT = 6;
   localparam int CFG_PIN_FUNC_BIT = 5;
   localparam int CFG_RANGE_BIT = 2;
   localparam logic [3:0] RATE_MAX_CODE = 4'h9;
   localparam logic [11:0] EXT_OFFSET = 12'h400; // 64 degrees in 1/16 steps
   // ==========================================================
   // timing: idle gap at the fastest code, doubling per lower code
   localparam int CLOCK_HZ = 200_000_000;
   localparam int FAST_PERIOD_US = 31250;
   localparam longint FAST_PERIOD_CYC = longint'(FAST_PERIOD_US) * CLOCK_HZ / 1_000_000;
   // ==========================================================
   // one finished measurement from the converter
   typedef struct packed {
      logic [11:0] local_temp;   // signed two's complement, 1/16 degree
      logic [11:0] remote_temp;
      logic remote_open;
   } sample_t;
   // limit set applied by the comparator
   typedef struct packed {
      logic [11:0] local_high;
      logic [11:0] local_low;
      logic [11:0] remote_high;
      logic [11:0] remote_low;
      logic [11:0] local_crit;
      logic [11:0] remote_crit;
      logic [11:0] hysteresis;
   } limits_t;
   // comparison outcome
   typedef struct packed {
      logic local_high;
      logic local_low;
      logic remote_high;
      logic remote_low;
      logic remote_open;
      logic local_crit;
      logic remote_crit;
      logic local_crit_clear;
      logic remote_crit_clear;
   } compare_t;
endpackage

// ---- conv_sequencer.sv ----
// conversion pacing: continuous, shutdown and one-shot start
`timescale 1ns/1ps
module conv_sequencer #(
   parameter longint FAST_CYC = tsense_pkg::FAST_PERIOD_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic shutdown,
   input wire logic one_shot,
   input wire logic [3:0] rate_code,
   input wire logic conv_done,
   output logic conv_start,
   output logic busy
);
   // refuse a gap length that the counter cannot serve
   if (FAST_CYC < 1) begin : g_bad_fast_cyc
      $error("FAST_CYC must be at least one");
   end
   typedef enum logic [1:0] {IDLE, CONVERT, GAP} seq_state_t;
   seq_state_t state_q;
   logic [40:0] gap_q;
   logic one_shot_q;
   logic [40:0] gap_len;
   logic [3:0] shift;

   // gap doubles per code step below the fastest code
   always_comb begin
      shift = (rate_code > tsense_pkg::RATE_MAX_CODE) ? 4'h0 : tsense_pkg::RATE_MAX_CODE - rate_code;
      gap_len = 41'(FAST_CYC) << shift;
   end

   // pending one-shot request, only taken while shut down
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         one_shot_q <= 1'b0;
      end else if (state_q == CONVERT) begin
         one_shot_q <= 1'b0;
      end else if (one_shot && shutdown) begin
         one_shot_q <= 1'b1;
      end
   end

   // sequence state; shutdown stops only after the running conversion
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= IDLE;
         gap_q <= '0;
         conv_start <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         unique case (state_q)
            IDLE: begin
               if (!shutdown || one_shot_q) begin
                  state_q <= CONVERT;
                  conv_start <= 1'b1;
               end
            end
            CONVERT: begin
               if (conv_done) begin
                  state_q <= GAP;
                  gap_q <= gap_len;
               end
            end
            GAP: begin
               if (shutdown) begin
                  state_q <= IDLE;
               end else if (gap_q <= 41'h1) begin
                  state_q <= CONVERT;
                  conv_start <= 1'b1;
               end else begin
                  gap_q <= gap_q - 41'h1;
               end
            end
         endcase
      end
   end

   // busy flag while a conversion runs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_q == IDLE && (!shutdown || one_shot_q)) ||
                 (state_q == CONVERT && !conv_done) ||
                 (state_q == GAP && !shutdown && gap_q <= 41'h1);
      end
   end
endmodule // conv_sequencer

// ---- limit_compare.sv ----
// limit comparison of a finished sample, with thermal hysteresis thresholds
`timescale 1ns/1ps
module limit_compare (
   input wire logic range_ext,
   input wire tsense_pkg::sample_t sample,
   input wire tsense_pkg::limits_t limits,
   output tsense_pkg::compare_t result
);
   // convert signed reading into the stored format of the active range
   function automatic logic [11:0] to_code(input logic [11:0] t, input logic ext);
      logic [12:0] v;
      v = {t[11], t} + (ext ? {1'b0, tsense_pkg::EXT_OFFSET} : 13'h0000);
      if (v[12]) begin
         to_code = 12'h000; // below the range floor
      end else if (!ext && t[11]) begin
         to_code = 12'h000;
      end else begin
         to_code = v[11:0];
      end
      to_code = ext ? to_code : {1'b0, to_code[10:0]};
   endfunction

   logic [11:0] loc;
   logic [11:0] rem;
   logic [12:0] loc_rel;
   logic [12:0] rem_rel;

   // both channels compared in the stored format
   always_comb begin
      loc = to_code(sample.local_temp, range_ext);
      rem = to_code(sample.remote_temp, range_ext);
      loc_rel = {1'b0, limits.local_crit} - {1'b0, limits.hysteresis};
      rem_rel = {1'b0, limits.remote_crit} - {1'b0, limits.hysteresis};
      result.local_high = loc > limits.local_high;
      result.local_low = loc < limits.local_low;
      result.remote_high = !sample.remote_open && rem > limits.remote_high;
      result.remote_low = !sample.remote_open && rem < limits.remote_low;
      result.remote_open = sample.remote_open;
      result.local_crit = loc > limits.local_crit;
      result.remote_crit = !sample.remote_open && rem > limits.remote_crit;
      result.local_crit_clear = loc_rel[12] ? 1'b0 : loc <= loc_rel[11:0];
      result.remote_crit_clear = rem_rel[12] ? 1'b0 : rem <= rem_rel[11:0];
   end
endmodule // limit_compare

// ---- temp_sensor_regs_checker.sv ----
// port assertions for the temperature monitor register block
`timescale 1ns/1ps
module temp_sensor_regs_checker #(
   parameter longint FAST_CYC = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic index_wr,
   input wire logic [7:0] index_wdata,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   input wire logic alert_response,
   input wire logic [7:0] rd_data,
   input wire logic conv_start,
   input wire logic alert_n,
   input wire logic secondary_thermal_output_n,
   input wire logic [7:0] register_index
);
   logic [7:0] cfg_q;
   logic [7:0] rate_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ==========================================================
   // shadow of the configuration register
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         cfg_q <= tsense_pkg::CFG_RESET;
      else if (data_wr && register_index == tsense_pkg::IDX_CFG_WR)
         cfg_q <= data_wdata & tsense_pkg::CFG_WR_MASK;
   end
   // shadow of the conversion rate register
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         rate_q <= tsense_pkg::RATE_RESET;
      else if (data_wr && register_index == tsense_pkg::IDX_RATE_WR)
         rate_q <= {4'h0, data_wdata[3:0]};
   end
   // ==========================================================
   // properties
   property p_index_load;
      index_wr |=> register_index == $past(index_wdata);
   endproperty
   property p_index_hold;
      !index_wr |=> $stable(register_index);
   endproperty
   property p_cfg_read;
      register_index == tsense_pkg::IDX_CFG_RD && $stable(register_index) && $stable(cfg_q)
         |-> rd_data == cfg_q;
   endproperty
   property p_rate_read;
      register_index == tsense_pkg::IDX_RATE_RD && $stable(register_index) && $stable(rate_q)
         |-> rd_data == rate_q;
   endproperty
   property p_mask;
      $past(cfg_q[7]) |-> alert_n;
   endproperty
   property p_sec_idle;
      !$past(cfg_q[5]) |-> secondary_thermal_output_n;
   endproperty
   property p_one_shot;
      data_wr && register_index == tsense_pkg::IDX_ONE_SHOT && cfg_q[6] |-> ##[1:4] conv_start;
   endproperty
   property p_alert_hold;
      $rose(alert_n) |-> $past(cfg_q[7]) || $past(cfg_q[5]) || $past(alert_response)
         || $past(alert_response, 2) || $past(alert_response, 3);
   endproperty
   a_index_load: assert property (p_index_load) else $error("index not loaded");
   a_index_hold: assert property (p_index_hold) else $error("index moved");
   a_cfg_read: assert property (p_cfg_read) else $error("config readback");
   a_rate_read: assert property (p_rate_read) else $error("rate readback");
   a_mask: assert property (p_mask) else $error("masked alert low");
   a_sec_idle: assert property (p_sec_idle) else $error("secondary pin active");
   a_one_shot: assert property (p_one_shot) else $error("one-shot no start");
   a_alert_hold: assert property (p_alert_hold) else $error("alert freed early");
   c_alert: cover property ($fell(alert_n));
   c_shot: cover property (data_wr && register_index == tsense_pkg::IDX_ONE_SHOT);
   c_sec: cover property ($fell(secondary_thermal_output_n));
endmodule // temp_sensor_regs_checker

bind temp_sensor_regs temp_sensor_regs_checker #(.FAST_CYC(FAST_CYC)) i_temp_sensor_regs_checker (
   .clock(clock), .rst(rst), .index_wr(index_wr), .index_wdata(index_wdata),
   .data_wr(data_wr), .data_wdata(data_wdata), .alert_response(alert_response),
   .rd_data(rd_data), .conv_start(conv_start), .alert_n(alert_n),
   .secondary_thermal_output_n(secondary_thermal_output_n), .register_index(register_index));

// ---- host_bus_model.sv ----
// host controller stand-in: index loads, data writes, reads, alert response
`timescale 1ns/1ps
module host_bus_model (
   input wire logic clock,
   input wire logic [7:0] rd_data,
   output logic index_wr,
   output logic [7:0] index_wdata,
   output logic data_wr,
   output logic [7:0] data_wdata,
   output logic data_rd,
   output logic alert_response
);
   // ==========================================================
   // idle bus at time zero
   initial begin
      {index_wr, data_wr, data_rd, alert_response} = 4'h0;
      index_wdata = 8'h00;
      data_wdata = 8'h00;
   end
   // every write and read starts by loading the index
   task automatic point(input logic [7:0] idx);
      @(posedge clock);
      #1 index_wr = 1'b1;
      index_wdata = idx;
      @(posedge clock);
      #1 index_wr = 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      point(idx);
      data_wr = 1'b1;
      data_wdata = val;
      @(posedge clock);
      #1 data_wr = 1'b0;
   endtask
   // read only after the index write has settled
   task automatic rd(input logic [7:0] idx, output logic [7:0] val);
      point(idx);
      repeat (2) @(posedge clock);
      #1 val = rd_data;
      data_rd = 1'b1;
      @(posedge clock);
      #1 data_rd = 1'b0;
   endtask
   task automatic ack();
      @(posedge clock);
      #1 alert_response = 1'b1;
      @(posedge clock);
      #1 alert_response = 1'b0;
   endtask
endmodule // host_bus_model

// ---- tb_temp_sensor_regs.sv ----
// self-checking bench for the temperature monitor register block
`timescale 1ns/1ps
module tb_temp_sensor_regs;
   logic clock, rst, index_wr, data_wr, data_rd, alert_response, conv_done, conv_start;
   logic alert_n, crit_n, sec_n;
   logic [7:0] index_wdata, data_wdata, rd_data, register_index;
   tsense_pkg::limits_t limits;
   tsense_pkg::sample_t sample;
   int err_total = 0, comparisons = 0, cycles = 0;
   temp_sensor_regs #(.FAST_CYC(4)) i_temp_sensor_regs (.clock(clock), .rst(rst),
      .index_wr(index_wr), .index_wdata(index_wdata), .data_wr(data_wr),
      .data_wdata(data_wdata), .data_rd(data_rd), .alert_response(alert_response),
      .limits(limits), .conv_done(conv_done), .sample(sample), .rd_data(rd_data),
      .conv_start(conv_start), .alert_n(alert_n), .thermal_limit_output_n(crit_n),
      .secondary_thermal_output_n(sec_n), .register_index(register_index));
   host_bus_model i_host_bus_model (.clock(clock), .rd_data(rd_data), .index_wr(index_wr),
      .index_wdata(index_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
      .data_rd(data_rd), .alert_response(alert_response));
   // ==========================================================
   // clock, converter stand-in and hang guard
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      conv_done = 1'b0;
      forever begin
         @(posedge clock);
         #1;
         if (conv_start) begin
            repeat (6) @(posedge clock);
            #1 conv_done = 1'b1;
            @(posedge clock);
            #1 conv_done = 1'b0;
         end
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         stop_test();
      end
   end
   // ==========================================================
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      i_host_bus_model.rd(idx, v);
      check(v, exp);
   endtask
   task automatic shot(input logic [11:0] lt, input logic [11:0] rt);
      sample.local_temp = lt;
      sample.remote_temp = rt;
      i_host_bus_model.wr(8'h0f, 8'h5a);
      repeat (40) begin
         @(posedge clock);
         if (conv_done) break;
      end
      repeat (4) @(posedge clock);
      #1;
   endtask
   task automatic stop_test();
      if (err_total == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      rst = 1'b1;
      limits = '0;
      limits.local_high = 12'h300;
      limits.remote_high = 12'h7f0;
      limits.local_crit = 12'h500;
      limits.remote_crit = 12'h7f0;
      limits.hysteresis = 12'h0a0;
      sample = '0;
      repeat (8) @(posedge clock);
      #1 rst = 1'b0;
      check(register_index, 8'h00);
      rchk(8'h03, 8'h00);
      rchk(8'h04, 8'h08);
      rchk(8'h00, 8'h00);
      rchk(8'h10, 8'h00);
      for (int c = 0; c <= 9; c++) begin
         i_host_bus_model.wr(8'h0a, 8'(c));
         rchk(8'h04, 8'(c));
      end
      i_host_bus_model.wr(8'h09, 8'h40);
      rchk(8'h03, 8'h40);
      repeat (60) @(posedge clock);
      begin
         int n = 0;
         repeat (100) begin
            @(posedge clock);
            if (conv_start) n++;
         end
         check(8'(n), 8'h00);
      end
      shot(12'h19a, 12'h0a1);
      rchk(8'h00, 8'h19);
      rchk(8'h15, 8'ha0);
      rchk(8'h01, 8'h0a);
      rchk(8'h10, 8'h10);
      rchk(8'h00, 8'h19);
      shot(12'h2b5, 12'h0a1);
      rchk(8'h15, 8'ha0);
      rchk(8'h00, 8'h2b);
      rchk(8'h01, 8'h0a);
      rchk(8'h02, 8'h00);
      shot(12'h2b5, 12'h0c7);
      rchk(8'h01, 8'h0c);
      rchk(8'h10, 8'h70);
      shot(12'h320, 12'h0d3);
      rchk(8'h01, 8'h0d);
      rchk(8'h02, 8'h40);
      check({7'h00, alert_n}, 8'h00);
      rchk(8'h02, 8'h40);
      shot(12'h190, 12'h0c7);
      rchk(8'h02, 8'h40);
      rchk(8'h02, 8'h00);
      check({7'h00, alert_n}, 8'h00);
      i_host_bus_model.ack();
      repeat (4) @(posedge clock);
      #1 check({7'h00, alert_n}, 8'h01);
      shot(12'h520, 12'h0c7);
      check({7'h00, crit_n}, 8'h00);
      rchk(8'h02, 8'h41);
      shot(12'h4a0, 12'h0c7);
      check({7'h00, crit_n}, 8'h00);
      shot(12'h460, 12'h0c7);
      check({7'h00, crit_n}, 8'h01);
      rchk(8'h02, 8'h40);
      i_host_bus_model.wr(8'h09, 8'h60);
      shot(12'h320, 12'h0c7);
      check({7'h00, sec_n}, 8'h00);
      shot(12'h190, 12'h0c7);
      check({7'h00, sec_n}, 8'h01);
      i_host_bus_model.wr(8'h09, 8'h44);
      shot(12'hfc0, 12'h0c7);
      rchk(8'h00, 8'h3c);
      rchk(8'h03, 8'h44);
      // open remote sensor latches until a read after it reconnects
      sample.remote_open = 1'b1;
      shot(12'hfc0, 12'h0c7);
      rchk(8'h02, 8'h44);
      sample.remote_open = 1'b0;
      shot(12'hfc0, 12'h0c7);
      rchk(8'h02, 8'h44);
      rchk(8'h02, 8'h40);
      i_host_bus_model.wr(8'h09, 8'hc4);
      repeat (4) @(posedge clock);
      #1 check({7'h00, alert_n}, 8'h01);
      stop_test();
   end
endmodule // tb_temp_sensor_regs
